/* core/islr_defs.svh */
// register offsets, field positions and reset values of the line interface register slice
`ifndef ISLR_DEFS_SVH
`define ISLR_DEFS_SVH
`define ISLR_OFF_FS_OVIEW   8'h13
`define ISLR_OFF_IFACE_SEL  8'h04
`define ISLR_OFF_IRQ_MASK   8'h05
`define ISLR_OFF_SLIP_STAT  8'h06
`define ISLR_OFF_RD_STA     8'h30
`define ISLR_OFF_DLYL       8'h31
`define ISLR_OFF_DLYH       8'h32
`define ISLR_OFF_MS_RX      8'h34
`define ISLR_OFF_MS_DF      8'h36
`define ISLR_OFF_WR_STA     8'h38
`define ISLR_OFF_D_TX       8'h3e
`define ISLR_OFF_BAC_S_TX   8'h3f
`define ISLR_BIT_SBIT       0
`define ISLR_BIT_BAC        5
`define ISLR_BIT_FR_SYNC    4
`define ISLR_BIT_T2_EXP     5
`define ISLR_BIT_INFO0      6
`define ISLR_BIT_G2G3       7
`define ISLR_BIT_RX_RDY     4
`define ISLR_BIT_SQT_SRC    2
`define ISLR_BIT_MS_SRC     3
`define ISLR_BIT_SLIP_MSK   0
`define ISLR_RST_BYTE       8'h00
`define ISLR_DLY_HALF       5
`define ISLR_FRAME_US       250
`define ISLR_CLK_MHZ        100
`define ISLR_FRAME_CYC      (`ISLR_FRAME_US * `ISLR_CLK_MHZ)
`endif

/* core/islr_pkg.sv */
// types shared by the line interface register slice
package islr_pkg;
  typedef struct packed {
    logic [7:0] adr;
    logic [7:0] dat;
    logic       we;
  } islr_req_t;
  typedef struct packed {
    logic [3:0] state;
    logic       fr_sync;
    logic       t2_exp;
    logic       info0;
    logic       nt_mode;
    logic       up_mode;
    logic       af0_sel;
  } islr_line_t;
endpackage : islr_pkg

/* core/islr_line_slot.sv */
// per line interface register copy: transmit bits, g2/g3 permit, delay and multiframe capture
`include "islr_defs.svh"
module islr_line_slot
  import islr_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       sel_i,
  input  wire islr_req_t  req_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire islr_line_t line_i,
  input  wire logic       g2g3_done_i,
  input  wire logic       dly_valid_i,
  input  wire logic [9:0] dly_count_i,
  input  wire logic       ms_rx_done_i,
  input  wire logic [3:0] ms_rx_bits_i,
  output logic [7:0]      dtx_reg,
  output logic [7:0]      bactx_reg,
  output logic [7:0]      msdf_reg,
  output logic            g2g3_reg,
  output logic [9:0]      dly_reg,
  output logic [3:0]      msrx_reg,
  output logic            rxrdy_reg,
  output logic [3:0]      force_reg,
  output logic            force_stb_reg
);
  logic wr_here;
  logic rdms_here;
  assign wr_here   = wr_i & sel_i;
  assign rdms_here = rd_i & sel_i & (req_i.adr == `ISLR_OFF_MS_RX);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dtx_reg   <= `ISLR_RST_BYTE;
      bactx_reg <= `ISLR_RST_BYTE;
      msdf_reg  <= `ISLR_RST_BYTE;
    end else if (wr_here) begin
      // reserved bits are kept as written; software writes zeros there  [R2]
      if (req_i.adr == `ISLR_OFF_D_TX) dtx_reg <= req_i.dat;
      if (req_i.adr == `ISLR_OFF_BAC_S_TX) bactx_reg <= req_i.dat;
      if (req_i.adr == `ISLR_OFF_MS_DF) msdf_reg <= req_i.dat;
    end
  end

  // set by software, cleared by the g2 to g3 step; the step wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      g2g3_reg <= 1'b0;
    end else if (g2g3_done_i) begin
      g2g3_reg <= 1'b0; // [R9]
    end else if (wr_here && req_i.adr == `ISLR_OFF_RD_STA && line_i.nt_mode) begin
      g2g3_reg <= req_i.dat[`ISLR_BIT_G2G3]; // [R9]
    end
  end

  // forced state goes out held, with a one-cycle strobe, never through the readout  [R10]
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      force_reg     <= 4'h0;
      force_stb_reg <= 1'b0;
    end else begin
      force_stb_reg <= wr_here && req_i.adr == `ISLR_OFF_WR_STA;
      if (wr_here && req_i.adr == `ISLR_OFF_WR_STA) force_reg <= req_i.dat[3:0];
    end
  end

  // both halves latched from one measurement so a split read stays consistent
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dly_reg <= 10'h000;
    end else if (dly_valid_i && line_i.nt_mode) begin
      dly_reg <= dly_count_i; // [R11] [R20]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      msrx_reg  <= 4'h0;
      rxrdy_reg <= 1'b0;
    end else begin
      if (ms_rx_done_i) msrx_reg <= ms_rx_bits_i; // [R17]
      // a new multiframe in the clearing cycle keeps the flag set
      if (ms_rx_done_i) rxrdy_reg <= 1'b1; // [R18]
      else if (rdms_here) rxrdy_reg <= 1'b0; // [R18]
    end
  end
endmodule : islr_line_slot

/* core/islr_regs.sv */
// line interface register slice: wishbone slave over four per interface register copies
// Notes on behaviour
// [R1] up mode s-bit from one of three sources; s/t mode uses it as M bit
// [R2] software writes zeros into reserved transmit register bits
// [R3] bac/s register bit 5 is the BAC bit for S/Q or T transmit
// [R4] software selects the line interface before touching array registers
// [R5] overview bits 0..3 mirror each interface's delayed frame sync selection
// [R6] any overview change raises a slip interrupt when the mask allows
// [R7] readout low nibble holds the binary activation state
// [R8] readout bits 4,5,6: frame sync, T2 expired, INFO 0 received
// [R9] bit 7 permits G2 to G3 in NT/LT mode, cleared after transition
// [R10] state is read through readout; forced only via separate write register
// [R11] round trip delay valid in NT/LT mode, refreshed every frame
// [R12] s/t mode counts framing transition delay in 1/32 bit steps
// [R13] up mode counts end of tx to start of rx in 1/32 bit steps
// [R14] delay is 10 bits: low 5 in low register, high 5 in high
// [R15] total delay is step times low plus 32 steps times high
// [R16] high register alone gives whole bit resolution
// [R17] receive nibble holds S/Q bits or four T bits in fixed order
// [R18] ready bit sets on complete multiframe; any read clears it (here only a read of the receive register 34 clears it)
// [R19] tx S/Q/T bits from bitmap when source bit 0, else BAC bit
// [R20] low and high delay fields come from the same measurement
//
// Chosen here: the Wishbone slave port.
`include "islr_defs.svh"
module islr_regs
  import islr_pkg::*;
#(
  parameter int unsigned N_IFACE   = 4,
  parameter int unsigned FRAME_CYC = `ISLR_FRAME_CYC
)(
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  cyc_i,
  input  wire logic                  stb_i,
  input  wire logic                  we_i,
  input  wire logic [9:0]            adr_i,
  input  wire logic [3:0]            sel_i,
  input  wire logic [31:0]           dat_i,
  output logic [31:0]                dat_o,
  output logic                       ack_o,
  output logic                       err_o,
  input  wire islr_line_t [N_IFACE-1:0] line_i,
  input  wire logic [N_IFACE-1:0]    g2g3_done_i,
  input  wire logic [N_IFACE-1:0]    tx_frame_mark_i,
  input  wire logic [N_IFACE-1:0]    rx_frame_mark_i,
  input  wire logic [N_IFACE-1:0]    ms_rx_done_i,
  input  wire logic [N_IFACE*4-1:0]  ms_rx_bits_i,
  input  wire logic [N_IFACE*4-1:0]  ms_tx_bitmap_i,
  input  wire logic [N_IFACE-1:0]    ms_s_reg_i,
  output logic [N_IFACE-1:0]         sbit_tx_o,
  output logic [N_IFACE*4-1:0]       sqt_tx_o,
  output logic [N_IFACE-1:0]         g2g3_permit_o,
  output logic [N_IFACE*4-1:0]       force_state_o,
  output logic [N_IFACE-1:0]         force_stb_o,
  output logic                       slip_irq_o
);
  // refused at elaboration: the overview and select field only serve up to four copies
  if (N_IFACE < 1 || N_IFACE > 4) begin : g_bad_iface
    $error("N_IFACE must be 1..4");
  end
  if (FRAME_CYC < 64) begin : g_bad_frame
    $error("FRAME_CYC too small");
  end

  localparam int SW = (N_IFACE > 1) ? $clog2(N_IFACE) : 1;

  // wishbone decode: byte address is four times the printed index
  logic      req_v;
  logic      mapped;
  islr_req_t req;
  logic      ack_reg;
  logic      err_reg;
  assign req_v   = cyc_i & stb_i & ~ack_reg & ~err_reg;
  assign req.adr = adr_i[9:2];
  assign req.dat = dat_i[7:0];
  assign req.we  = we_i;

  always_comb begin
    case (req.adr)
      `ISLR_OFF_FS_OVIEW, `ISLR_OFF_IFACE_SEL, `ISLR_OFF_IRQ_MASK, `ISLR_OFF_SLIP_STAT,
      `ISLR_OFF_RD_STA, `ISLR_OFF_DLYL, `ISLR_OFF_DLYH, `ISLR_OFF_MS_RX,
      `ISLR_OFF_MS_DF, `ISLR_OFF_WR_STA, `ISLR_OFF_D_TX, `ISLR_OFF_BAC_S_TX: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  logic wr_go;
  logic rd_go;
  assign wr_go = req_v & mapped & we_i & sel_i[0];
  assign rd_go = req_v & mapped & ~we_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      ack_reg <= req_v & mapped;
      err_reg <= req_v & ~mapped;
    end
  end
  assign ack_o = ack_reg;
  assign err_o = err_reg;

  // interface select and interrupt mask registers
  logic [7:0] iface_sel_reg;
  logic [7:0] irq_mask_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      iface_sel_reg <= `ISLR_RST_BYTE;
      irq_mask_reg  <= `ISLR_RST_BYTE;
    end else if (wr_go) begin
      if (req.adr == `ISLR_OFF_IFACE_SEL) iface_sel_reg <= req.dat; // [R4]
      if (req.adr == `ISLR_OFF_IRQ_MASK) irq_mask_reg <= req.dat;
    end
  end
  logic [SW-1:0] cur;
  assign cur = iface_sel_reg[SW-1:0];

  // per interface delay counters and frame timing
  logic [N_IFACE-1:0]     dly_valid;
  logic [9:0]             dly_cnt [N_IFACE];
  logic [N_IFACE-1:0]     dly_run;
  logic [7:0]             dtx   [N_IFACE];
  logic [7:0]             bactx [N_IFACE];
  logic [7:0]             msdf  [N_IFACE];
  logic [N_IFACE-1:0]     g2g3;
  logic [9:0]             dly   [N_IFACE];
  logic [3:0]             msrx  [N_IFACE];
  logic [N_IFACE-1:0]     rxrdy;
  logic [3:0]             frc   [N_IFACE];
  logic [N_IFACE-1:0]     frc_stb;
  logic [N_IFACE-1:0]     marks_tx_s1;
  logic [N_IFACE-1:0]     marks_tx_s2;
  logic [N_IFACE-1:0]     marks_rx_s1;
  logic [N_IFACE-1:0]     marks_rx_s2;
  logic [N_IFACE-1:0]     marks_tx_d;
  logic [N_IFACE-1:0]     marks_rx_d;

  // frame marks come from the line clock side: two flops first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      marks_tx_s1 <= '0;
      marks_tx_s2 <= '0;
      marks_rx_s1 <= '0;
      marks_rx_s2 <= '0;
      marks_tx_d  <= '0;
      marks_rx_d  <= '0;
    end else begin
      marks_tx_s1 <= tx_frame_mark_i;
      marks_tx_s2 <= marks_tx_s1;
      marks_rx_s1 <= rx_frame_mark_i;
      marks_rx_s2 <= marks_rx_s1;
      marks_tx_d  <= marks_tx_s2;
      marks_rx_d  <= marks_rx_s2;
    end
  end

  // step clock: 1/32 bit is 162.8 ns (s/t) or 81.4 ns (up); kept as tick divider
  localparam int unsigned STEP_ST_PS = 162800;
  localparam int unsigned STEP_UP_PS = 81400;
  localparam int unsigned CLK_PS     = 1000000 / `ISLR_CLK_MHZ;
  localparam logic [7:0]  DIV_ST     = 8'((STEP_ST_PS + CLK_PS / 2) / CLK_PS);
  localparam logic [7:0]  DIV_UP     = 8'((STEP_UP_PS + CLK_PS / 2) / CLK_PS);
  logic [7:0] step_div [N_IFACE];

  genvar g;
  generate
    for (g = 0; g < N_IFACE; g++) begin : g_if
      logic tx_edge;
      logic rx_edge;
      logic step;
      assign tx_edge = marks_tx_s2[g] & ~marks_tx_d[g];
      assign rx_edge = marks_rx_s2[g] & ~marks_rx_d[g];
      assign step    = step_div[g] == 8'h00;

      // s/t counts framing transition to transition, up counts tx end to rx start  [R12] [R13]
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          dly_run[g]   <= 1'b0;
          dly_cnt[g]   <= 10'h000;
          dly_valid[g] <= 1'b0;
          step_div[g]  <= 8'h00;
        end else begin
          dly_valid[g] <= 1'b0;
          if (tx_edge) begin
            dly_run[g]  <= 1'b1;
            dly_cnt[g]  <= 10'h000;
            step_div[g] <= line_i[g].up_mode ? DIV_UP - 8'h01 : DIV_ST - 8'h01;
          end else if (dly_run[g]) begin
            step_div[g] <= step ? (line_i[g].up_mode ? DIV_UP - 8'h01 : DIV_ST - 8'h01)
                                : step_div[g] - 8'h01;
            if (step && dly_cnt[g] != 10'h3ff) dly_cnt[g] <= dly_cnt[g] + 10'h001;
            if (rx_edge) begin
              dly_run[g]   <= 1'b0;
              dly_valid[g] <= 1'b1; // [R11]
            end
          end
        end
      end

      islr_line_slot u_slot (
        .clk_i         (clk_i),
        .rst_i         (rst_i),
        .sel_i         (cur == SW'(g)),
        .req_i         (req),
        .wr_i          (wr_go),
        .rd_i          (rd_go),
        .line_i        (line_i[g]),
        .g2g3_done_i   (g2g3_done_i[g]),
        .dly_valid_i   (dly_valid[g]),
        .dly_count_i   (dly_cnt[g]),
        .ms_rx_done_i  (ms_rx_done_i[g]),
        .ms_rx_bits_i  (ms_rx_bits_i[g*4 +: 4]),
        .dtx_reg       (dtx[g]),
        .bactx_reg     (bactx[g]),
        .msdf_reg      (msdf[g]),
        .g2g3_reg      (g2g3[g]),
        .dly_reg       (dly[g]),
        .msrx_reg      (msrx[g]),
        .rxrdy_reg     (rxrdy[g]),
        .force_reg     (frc[g]),
        .force_stb_reg (frc_stb[g])
      );

      // S/Q or T source: bitmap, or BAC bit of the D register ORed with that of the bac/s register  [R19] [R3]
      assign sqt_tx_o[g*4 +: 4] = msdf[g][`ISLR_BIT_SQT_SRC]
                                  ? {4{dtx[g][`ISLR_BIT_BAC] | bactx[g][`ISLR_BIT_BAC]}}
                                  : ms_tx_bitmap_i[g*4 +: 4];
      // s-bit: superframe register, D register or bac/s register; in s/t this is M  [R1]
      assign sbit_tx_o[g] = ~msdf[g][`ISLR_BIT_MS_SRC] ? ms_s_reg_i[g]
                            : (dtx[g][`ISLR_BIT_SBIT] | bactx[g][`ISLR_BIT_SBIT]);
      assign g2g3_permit_o[g]          = g2g3[g]; // [R9]
      assign force_state_o[g*4 +: 4]   = frc[g]; // [R10]
      assign force_stb_o[g]            = frc_stb[g];
    end
  endgenerate

  // overview mirror and slip detection
  logic [3:0] oview;
  logic [3:0] oview_reg;
  logic       slip_reg;
  always_comb begin
    oview = 4'h0;
    for (int i = 0; i < N_IFACE; i++) oview[i] = line_i[i].af0_sel; // [R5]
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oview_reg <= 4'h0;
      slip_reg  <= 1'b0;
    end else begin
      oview_reg <= oview;
      // a change arriving with the clear keeps the flag set
      if (oview != oview_reg) slip_reg <= 1'b1; // [R6]
      else if (wr_go && req.adr == `ISLR_OFF_SLIP_STAT && req.dat[0]) slip_reg <= 1'b0;
    end
  end
  assign slip_irq_o = slip_reg & irq_mask_reg[`ISLR_BIT_SLIP_MSK]; // [R6]

  // read mux, registered for a one-cycle answer
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    case (req.adr)
      `ISLR_OFF_FS_OVIEW:  rd_byte = {4'h0, oview_reg}; // [R5]
      `ISLR_OFF_IFACE_SEL: rd_byte = iface_sel_reg;
      `ISLR_OFF_IRQ_MASK:  rd_byte = irq_mask_reg;
      `ISLR_OFF_SLIP_STAT: rd_byte = {7'h00, slip_reg};
      `ISLR_OFF_RD_STA:    rd_byte = {g2g3[cur], line_i[cur].info0, line_i[cur].t2_exp & line_i[cur].nt_mode,
                                      line_i[cur].fr_sync, line_i[cur].state}; // [R7] [R8] [R10]
      `ISLR_OFF_DLYL:      rd_byte = {3'h0, dly[cur][`ISLR_DLY_HALF-1:0]}; // [R14] [R15]
      `ISLR_OFF_DLYH:      rd_byte = {3'h0, dly[cur][9:`ISLR_DLY_HALF]}; // [R14] [R16]
      `ISLR_OFF_MS_RX:     rd_byte = {3'h0, rxrdy[cur], msrx[cur]}; // [R17] [R18]
      default:             rd_byte = 8'h00;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) dat_o <= 32'h0000_0000;
    else if (rd_go) dat_o <= {24'h00_0000, rd_byte};
  end
endmodule : islr_regs

/* verif/islr_regs_properties.sv */
// concurrent checks on the ports of the line interface register slice
module islr_regs_checker
  import islr_pkg::*;
#(
  parameter int unsigned N_IFACE = 4
)(
  input wire logic                     clk_i,
  input wire logic                     rst_i,
  input wire logic                     cyc_i,
  input wire logic                     stb_i,
  input wire logic                     we_i,
  input wire logic [9:0]               adr_i,
  input wire logic [3:0]               sel_i,
  input wire logic [31:0]              dat_i,
  input wire logic [31:0]              dat_o,
  input wire logic                     ack_o,
  input wire logic                     err_o,
  input wire islr_line_t [N_IFACE-1:0] line_i,
  input wire logic [N_IFACE-1:0]       g2g3_done_i,
  input wire logic [N_IFACE-1:0]       g2g3_permit_o,
  input wire logic [N_IFACE-1:0]       force_stb_o,
  input wire logic                     slip_irq_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic               take;
  logic [1:0]         isel_reg;
  logic               mask_reg;
  logic [N_IFACE-1:0] af0_vec;
  logic [N_IFACE-1:0] nt_vec;
  logic [6:0]         sta_vec;
  assign take = cyc_i && stb_i && !ack_o && !err_o;
  // t2 flag only exists in nt/lt mode
  assign sta_vec = {line_i[isel_reg].info0, line_i[isel_reg].t2_exp & line_i[isel_reg].nt_mode,
                    line_i[isel_reg].fr_sync, line_i[isel_reg].state};
  always_comb begin
    for (int k = 0; k < N_IFACE; k++) begin
      af0_vec[k] = line_i[k].af0_sel;
      nt_vec[k]  = line_i[k].nt_mode;
    end
  end
  // shadows follow writes at the take edge, as the slice does
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      isel_reg <= 2'h0;
      mask_reg <= 1'b0;
    end else if (take && we_i && sel_i[0]) begin
      if (adr_i[9:2] == 8'h04) isel_reg <= dat_i[1:0];
      if (adr_i[9:2] == 8'h05) mask_reg <= dat_i[0];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_next_cycle: assert property (take |=> (ack_o || err_o)) else $error("request not answered next cycle");
  a_ack_single: assert property ((ack_o || err_o) |=> !(ack_o || err_o)) else $error("answer longer than one cycle");
  a_read_upper_zero: assert property ((ack_o && !we_i) |-> dat_o[31:8] == 24'h0) else $error("upper read bits set");
  a_ovw_mirror: assert property ((ack_o && !we_i && adr_i[9:2] == 8'h13)
    |-> dat_o[7:0] == 8'($past(af0_vec, 2))) else $error("overview differs from sync selections");
  a_sta_readout: assert property ((ack_o && !we_i && adr_i[9:2] == 8'h30)
    |-> dat_o[6:0] == $past(sta_vec)) else $error("state readout differs from line state");
  a_permit_bit: assert property ((ack_o && !we_i && adr_i[9:2] == 8'h30)
    |-> dat_o[7] == $past(g2g3_permit_o[isel_reg])) else $error("readout bit 7 differs from permit");
  a_permit_clear: assert property (|g2g3_done_i |=> (g2g3_permit_o & $past(g2g3_done_i)) == '0)
    else $error("permit not cleared by transition");
  a_permit_te_only: assert property ((g2g3_permit_o & ~$past(g2g3_permit_o) & ~$past(nt_vec)) == '0)
    else $error("permit set outside nt mode");
  a_force_cause: assert property (|force_stb_o |-> ack_o && we_i && adr_i[9:2] == 8'h38)
    else $error("force strobe without state write");
  a_force_pulse: assert property (|force_stb_o |=> force_stb_o == '0) else $error("force strobe too long");
  a_slip_masked: assert property (slip_irq_o |-> mask_reg) else $error("slip interrupt while masked");
  a_dly_width: assert property ((ack_o && !we_i && (adr_i[9:2] == 8'h31 || adr_i[9:2] == 8'h32))
    |-> dat_o[7:5] == 3'h0) else $error("delay field wider than five bits");
endmodule : islr_regs_checker

/* verif/islr_line_model.sv */
// far-end line partner: frame markers, multiframe receive and g2/g3 events
module islr_line_model (
  input  wire logic  clk_i,
  output logic [3:0] tx_mark_o,
  output logic [3:0] rx_mark_o,
  output logic [3:0] ms_done_o,
  output logic [15:0] ms_bits_o,
  output logic [3:0] g2g3_done_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    tx_mark_o = 4'h0;
    rx_mark_o = 4'h0;
    ms_done_o = 4'h0;
    ms_bits_o = 16'h0;
    g2g3_done_o = 4'h0;
  end
  // remote answers dly clocks after our frame marker
  task frame(input int i, input int dly);
    @(posedge clk_i);
    tx_mark_o[i] <= 1'b1;
    repeat (dly) @(posedge clk_i);
    rx_mark_o[i] <= 1'b1;
    repeat (8) @(posedge clk_i);
    tx_mark_o[i] <= 1'b0;
    rx_mark_o[i] <= 1'b0;
  endtask : frame
  // bits only valid with the pulse, inverted afterwards
  task ms(input int i, input logic [3:0] b);
    @(posedge clk_i);
    ms_done_o[i] <= 1'b1;
    ms_bits_o[i*4+:4] <= b;
    @(posedge clk_i);
    ms_done_o[i] <= 1'b0;
    ms_bits_o[i*4+:4] <= ~b;
  endtask : ms
  task g2g3(input int i);
    @(posedge clk_i);
    g2g3_done_o[i] <= 1'b1;
    @(posedge clk_i);
    g2g3_done_o[i] <= 1'b0;
  endtask : g2g3
endmodule : islr_line_model

/* verif/test_islr_regs.sv */
// self-checking bench of the line interface register slice
module test_islr_regs
  import islr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic             clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, err_o, slip_irq_o;
  logic [9:0]       adr_i, mon_e;
  logic [3:0]       sel_i, g2g3_done_i, tx_mark, rx_mark, ms_done, ms_s, sbit_tx_o, g2g3_permit_o, force_stb_o;
  logic [31:0]      dat_i, dat_o, rnd_state;
  logic [15:0]      ms_bits, ms_bitmap, sqt_tx_o, force_state_o;
  islr_line_t [3:0] line_i;
  logic [9:0]       exp_q[$];
  int               n_errors, n_tests, cycles;
  islr_regs #(.N_IFACE(4), .FRAME_CYC(64)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
    .line_i(line_i), .g2g3_done_i(g2g3_done_i), .tx_frame_mark_i(tx_mark), .rx_frame_mark_i(rx_mark),
    .ms_rx_done_i(ms_done), .ms_rx_bits_i(ms_bits), .ms_tx_bitmap_i(ms_bitmap), .ms_s_reg_i(ms_s),
    .sbit_tx_o(sbit_tx_o), .sqt_tx_o(sqt_tx_o), .g2g3_permit_o(g2g3_permit_o), .force_state_o(force_state_o),
    .force_stb_o(force_stb_o), .slip_irq_o(slip_irq_o));
  islr_line_model m_u (.clk_i(clk_i), .tx_mark_o(tx_mark), .rx_mark_o(rx_mark), .ms_done_o(ms_done),
    .ms_bits_o(ms_bits), .g2g3_done_o(g2g3_done_i));
  function automatic logic [31:0] rnd();
    rnd_state ^= rnd_state << 13;
    rnd_state ^= rnd_state >> 17;
    rnd_state ^= rnd_state << 5;
    return rnd_state;
  endfunction : rnd
  function automatic logic [7:0] sta(input int i, input logic p);
    return {p, line_i[i].info0, line_i[i].t2_exp & line_i[i].nt_mode, line_i[i].fr_sync, line_i[i].state};
  endfunction : sta
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask : chk
  // e holds {err expected, data checked, data}
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic [9:0] e);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    dat_i <= {24'h0, d};
    sel_i <= 4'h1;
    exp_q.push_back(e);
    // no local limit: only the run ceiling ends a wait
    do begin
      @(posedge clk_i);
    end while (!(ack_o === 1'b1 || err_o === 1'b1));
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic rd(input logic [7:0] idx, input logic [7:0] x);
    wb(1'b0, idx, 8'h00, {2'b01, x});
  endtask : rd
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    wb(1'b1, idx, d, 10'h000);
  endtask : wr
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 || err_o === 1'b1) begin
      mon_e = (exp_q.size() > 0) ? exp_q.pop_front() : 10'h3ff;
      n_tests++;
      if (err_o !== mon_e[9] || (mon_e[8] && dat_o[7:0] !== mon_e[7:0])) begin
        $display("Error bus answer expected %h seen %h", mon_e, {err_o, dat_o[7:0]});
        n_errors++;
      end
    end
  end
  // ceiling well above the longest delay runs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      $display("Error run length expected finish seen hang");
      n_errors++;
      end_sim();
    end
  end
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    logic [31:0] r;
    static int ks[3] = '{2, 37, 1023};
    {n_errors, n_tests, cycles} = '0;
    rnd_state = 32'h4cdda071;
    {rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i, ms_bitmap, ms_s} = '0;
    rst_i = 1'b1;
    line_i = '0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h30, 8'h00);
    rd(8'h13, 8'h00);
    rd(8'h34, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      line_i[i] <= r[9:0];
      wr(8'h04, 8'(i));
      rd(8'h30, sta(i, 1'b0));
    end
    rd(8'h13, {4'h0, line_i[3].af0_sel, line_i[2].af0_sel, line_i[1].af0_sel, line_i[0].af0_sel});
    wr(8'h05, 8'h01);
    wr(8'h06, 8'h01);
    chk("slip cleared", 8'h00, 8'(slip_irq_o));
    line_i[1].af0_sel <= !line_i[1].af0_sel;
    repeat (4) @(posedge clk_i);
    chk("slip raised", 8'h01, 8'(slip_irq_o));
    wr(8'h06, 8'h01);
    wr(8'h05, 8'h00);
    line_i[1].af0_sel <= !line_i[1].af0_sel;
    repeat (4) @(posedge clk_i);
    chk("slip masked", 8'h00, 8'(slip_irq_o));
    $display("test readout done");
    line_i[0].nt_mode <= 1'b1;
    wr(8'h04, 8'h00);
    for (int m = 0; m < 2; m++) begin
      line_i[0].up_mode <= m[0];
      foreach (ks[j]) begin
        m_u.frame(0, (ks[j] << (4 - m)) + (8 >> m));
        rd(8'h31, 8'(ks[j] & 31));
        rd(8'h32, 8'(ks[j] >> 5));
      end
    end
    line_i[0].nt_mode <= 1'b0;
    m_u.frame(0, 88);
    rd(8'h31, 8'h1f);
    rd(8'h32, 8'h1f);
    $display("test delay done");
    line_i[1].nt_mode <= 1'b1;
    line_i[2].nt_mode <= 1'b0;
    wr(8'h04, 8'h01);
    wr(8'h30, 8'h80);
    chk("permit set", 8'h01, 8'(g2g3_permit_o[1]));
    rd(8'h30, sta(1, 1'b1));
    m_u.g2g3(1);
    @(posedge clk_i);
    chk("permit clear", 8'h00, 8'(g2g3_permit_o[1]));
    rd(8'h30, sta(1, 1'b0));
    wr(8'h04, 8'h02);
    wr(8'h30, 8'h80);
    chk("permit te", 8'h00, 8'(g2g3_permit_o[2]));
    r = rnd();
    wr(8'h04, 8'h03);
    wr(8'h38, {4'h0, r[3:0]});
    chk("force state", {4'h0, r[3:0]}, {4'h0, force_state_o[15:12]});
    rd(8'h30, sta(3, 1'b0));
    $display("test state done");
    r = rnd();
    wr(8'h04, 8'h02);
    m_u.ms(2, r[3:0]);
    rd(8'h34, {3'h0, 1'b1, r[3:0]});
    rd(8'h34, {3'h0, 1'b0, r[3:0]});
    r = rnd();
    ms_bitmap <= r[15:0];
    ms_s <= r[19:16];
    wr(8'h04, 8'h00);
    wr(8'h36, 8'h00);
    chk("sqt bitmap", {4'h0, r[3:0]}, {4'h0, sqt_tx_o[3:0]});
    chk("sbit reg", 8'(r[16]), 8'(sbit_tx_o[0]));
    for (int b = 0; b < 2; b++) begin
      wr(8'h3e, {2'b00, b[0], 4'h0, b[0]});
      wr(8'h3f, {2'b00, b[0], 4'h0, b[0]});
      wr(8'h36, 8'h0c);
      chk("sqt bac", 8'(b[0]), 8'(sqt_tx_o[0]));
      chk("sbit chan", 8'(b[0]), 8'(sbit_tx_o[0]));
    end
    wb(1'b0, 8'h7f, 8'h00, 10'h200);
    $display("test transmit done");
    end_sim();
  end
endmodule : test_islr_regs
bind islr_regs islr_regs_checker #(.N_IFACE(N_IFACE)) chk_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .err_o(err_o), .line_i(line_i), .g2g3_done_i(g2g3_done_i), .g2g3_permit_o(g2g3_permit_o),
  .force_stb_o(force_stb_o), .slip_irq_o(slip_irq_o));
